// ### verilog/oprs_top.v
// Display driver reset defaults, display state and command decoding.
// Assumes APB master on pclk; serial pins are asynchronous to pclk.
//
// Contract
// RULE1: Host powers logic, inits, clears, enables panel, waits 100ms, then display on.
// RULE2: Host sends display off, drops panel supply, waits 100ms, then logic.
// RULE3: Host leaves panel supply floating when it is off.
// RULE4: Low reset input puts driver into default state, 128x64 mode.
// RULE5: After reset display off, normal mode like A4h.
// RULE6: After reset segment and common mappings are normal, at address 00h.
// RULE7: Reset clears partial bits in serial shift register.
// RULE8: After reset start line points at memory line 0.
// RULE9: After reset column counter holds 0.
// RULE10: After reset common scan direction is normal.
// RULE11: After reset contrast is 7Fh.
// RULE12: Host may pulse reset and reinitialise after noise.
// RULE13: Host drives select low for commands, high for data, one strobe per byte.
// RULE14: Host enables panel supply only after all init writes finish.
`timescale 1ns/1ps
`default_nettype none
`include "oprs_defines.vh"
module oprs_top (
	// APB slave
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Serial interface pins
	input wire chip_select_n,
	input wire serial_clk,
	input wire serial_din,
	input wire cmd_data_select,
	// Display state outputs
	output reg display_on_r,
	output reg [7:0] contrast_r,
	output reg [7:0] column_r,
	output reg [5:0] start_line_r
);
	reg [1:0] cs_sync_r;
	reg [1:0] clk_sync_r;
	reg [1:0] din_sync_r;
	reg [1:0] dc_sync_r;
	reg invert_r;
	reg all_on_r;
	reg seg_remap_r;
	reg com_rev_r;
	reg [5:0] mux_r;
	reg contrast_pend_r;
	reg panel_en_r;
	reg [6:0] state_bits;
	reg [31:0] rd_word;
	wire [7:0] ser_byte;
	wire ser_vld;
	wire [2:0] ser_cnt;
	wire apb_wr;
	wire apb_rd;
	wire cmd_wr;
	wire data_wr;
	wire any_cmd;
	wire [7:0] any_byte;
	wire any_data;

	function addr_hit;
		input [11:0] a;
		input [11:0] ref_a;
		begin
			addr_hit = (a == ref_a);
		end
	endfunction

	// Pin synchronisers, first stage read only by the second
	// Select kept raw, idle high, so no gate sits before the first flop
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_sync_r <= 2'h3;
			clk_sync_r <= 2'h0;
			din_sync_r <= 2'h0;
			dc_sync_r <= 2'h0;
		end else begin
			cs_sync_r <= {cs_sync_r[0], chip_select_n};
			clk_sync_r <= {clk_sync_r[0], serial_clk};
			din_sync_r <= {din_sync_r[0], serial_din};
			dc_sync_r <= {dc_sync_r[0], cmd_data_select};
		end
	end

	oprs_shift u_shift (
		.pclk(pclk),
		.presetn(presetn),
		.cs_active(~cs_sync_r[1]),
		.sclk_q(clk_sync_r[1]),
		.sdin_q(din_sync_r[1]),
		.byte_r(ser_byte),
		.byte_vld_r(ser_vld),
		.bit_cnt_r(ser_cnt)
	);

	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && !penable && !pwrite;
	assign cmd_wr = apb_wr && addr_hit(paddr, `OPRS_ADDR_CMD);
	assign data_wr = apb_wr && addr_hit(paddr, `OPRS_ADDR_DATA);
	// Command bytes from serial when select was low
	assign any_cmd = cmd_wr || (ser_vld && !dc_sync_r[1]);
	assign any_data = data_wr || (ser_vld && dc_sync_r[1]);
	assign any_byte = (cmd_wr || data_wr) ? pwdata[7:0] : ser_byte;

	// Display state; APB byte wins over a coincident serial byte
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// RULE4: defaults, 128x64
			mux_r <= `OPRS_RST_MUX;
			// RULE5: off, follow memory
			display_on_r <= 1'b0;
			invert_r <= 1'b0;
			all_on_r <= 1'b0;
			// RULE6: normal mappings
			seg_remap_r <= 1'b0;
			// RULE10: normal scan
			com_rev_r <= 1'b0;
			// RULE8: start line 0
			start_line_r <= `OPRS_RST_START;
			// RULE9: column zero
			column_r <= `OPRS_RST_COLUMN;
			// RULE11: contrast default
			contrast_r <= `OPRS_RST_CONTRAST;
			contrast_pend_r <= 1'b0;
			panel_en_r <= 1'b0;
		end else begin
			if (any_cmd && contrast_pend_r) begin
				contrast_r <= any_byte;
				contrast_pend_r <= 1'b0;
			end else if (any_cmd) begin
				case (any_byte)
					`OPRS_CMD_DISP_OFF: display_on_r <= 1'b0;
					`OPRS_CMD_DISP_ON: display_on_r <= 1'b1;
					`OPRS_CMD_FOLLOW_RAM: all_on_r <= 1'b0;
					`OPRS_CMD_ALL_ON: all_on_r <= 1'b1;
					`OPRS_CMD_NORMAL: invert_r <= 1'b0;
					`OPRS_CMD_INVERSE: invert_r <= 1'b1;
					`OPRS_CMD_SEG_NORM: seg_remap_r <= 1'b0;
					`OPRS_CMD_SEG_REMAP: seg_remap_r <= 1'b1;
					`OPRS_CMD_COM_NORM: com_rev_r <= 1'b0;
					`OPRS_CMD_COM_REV: com_rev_r <= 1'b1;
					`OPRS_CMD_CONTRAST: contrast_pend_r <= 1'b1;
					default: begin
						// Start line set: 40h..7Fh
						if (any_byte[7:6] == 2'b01) begin
							start_line_r <= any_byte[5:0];
						end
					end
				endcase
			end else if (any_data) begin
				// Column wraps after 8 bits; no page logic here
				column_r <= column_r + 8'h01;
			end
			if (apb_wr && addr_hit(paddr, `OPRS_ADDR_POWER)) begin
				panel_en_r <= pwdata[0];
			end
		end
	end

	// State word fields placed by their defined positions
	always @* begin
		state_bits = 7'h00;
		state_bits[`OPRS_ST_DISP_ON] = display_on_r;
		state_bits[`OPRS_ST_INVERT] = invert_r;
		state_bits[`OPRS_ST_ALL_ON] = all_on_r;
		state_bits[`OPRS_ST_SEG_REMAP] = seg_remap_r;
		state_bits[`OPRS_ST_COM_REV] = com_rev_r;
		state_bits[`OPRS_ST_CMD_DATA] = dc_sync_r[1];
		state_bits[`OPRS_ST_PANEL_EN] = panel_en_r;
	end

	// Unaligned or beyond the last register
	function addr_bad;
		input [11:0] a;
		begin
			addr_bad = (a > `OPRS_ADDR_POWER) || (a[1:0] != 2'h0);
		end
	endfunction

	// Read mux; write-only and unmapped addresses read zero
	always @* begin
		rd_word = 32'h00000000;
		case (paddr)
			`OPRS_ADDR_STATE: begin
				rd_word = {25'h0000000, state_bits};
			end
			`OPRS_ADDR_CONTRAST: begin
				rd_word = {24'h000000, contrast_r};
			end
			`OPRS_ADDR_POS: begin
				// Bit count shows a partial serial byte to software
				rd_word = {9'h000, ser_cnt, mux_r, start_line_r, column_r};
			end
			`OPRS_ADDR_POWER: begin
				rd_word = {31'h00000000, panel_en_r};
			end
			default: begin
				rd_word = 32'h00000000;
			end
		endcase
	end

	// APB: one wait-free access phase, read data staged in setup
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			// Error rides with pready; a refused write changes nothing
			pslverr <= psel && !penable && addr_bad(paddr);
			// Read data held until the next read
			if (apb_rd) begin
				prdata <= rd_word;
			end
		end
	end
endmodule
`default_nettype wire

// ### include/oprs_defines.vh
// Constants for the display driver reset and power-state block.
// Assumes inclusion by bare name from design files only.
`ifndef OPRS_DEFINES_VH
`define OPRS_DEFINES_VH

// Register byte addresses
`define OPRS_ADDR_CMD 12'h000
`define OPRS_ADDR_DATA 12'h004
`define OPRS_ADDR_STATE 12'h008
`define OPRS_ADDR_CONTRAST 12'h00C
`define OPRS_ADDR_POS 12'h010
`define OPRS_ADDR_POWER 12'h014

// State register field positions
`define OPRS_ST_DISP_ON 0
`define OPRS_ST_INVERT 1
`define OPRS_ST_ALL_ON 2
`define OPRS_ST_SEG_REMAP 3
`define OPRS_ST_COM_REV 4
`define OPRS_ST_CMD_DATA 5
`define OPRS_ST_PANEL_EN 6

// Reset values
`define OPRS_RST_CONTRAST 8'h7F
`define OPRS_RST_MUX 6'h3F
`define OPRS_RST_START 6'h00
`define OPRS_RST_COLUMN 8'h00

// Command codes
`define OPRS_CMD_DISP_OFF 8'hAE
`define OPRS_CMD_DISP_ON 8'hAF
`define OPRS_CMD_FOLLOW_RAM 8'hA4
`define OPRS_CMD_ALL_ON 8'hA5
`define OPRS_CMD_NORMAL 8'hA6
`define OPRS_CMD_INVERSE 8'hA7
`define OPRS_CMD_SEG_NORM 8'hA0
`define OPRS_CMD_SEG_REMAP 8'hA1
`define OPRS_CMD_COM_NORM 8'hC0
`define OPRS_CMD_COM_REV 8'hC8
`define OPRS_CMD_CONTRAST 8'h81

`endif

// ### verilog/oprs_shift.v
// Serial byte receiver: shifts sdin_q bits msb first; oprs_top tags each byte by cmd_data_select.
// Assumes sclk_q and sdin_q are already synchronised to pclk.
`timescale 1ns/1ps
`default_nettype none
module oprs_shift (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Serial input, synchronised
	input wire cs_active,
	input wire sclk_q,
	input wire sdin_q,
	// Byte out
	output reg [7:0] byte_r,
	output reg byte_vld_r,
	output reg [2:0] bit_cnt_r
);
	reg sclk_d_r;
	reg [7:0] shreg_r;

	always @(posedge pclk or negedge presetn) begin
		// RULE7: shifter cleared
		if (!presetn) begin
			sclk_d_r <= 1'b0;
			shreg_r <= 8'h00;
			bit_cnt_r <= 3'h0;
			byte_r <= 8'h00;
			byte_vld_r <= 1'b0;
		end else begin
			sclk_d_r <= sclk_q;
			byte_vld_r <= 1'b0;
			if (!cs_active) begin
				// Deselect drops a partial byte
				bit_cnt_r <= 3'h0;
			end else if (sclk_q && !sclk_d_r) begin
				shreg_r <= {shreg_r[6:0], sdin_q};
				bit_cnt_r <= bit_cnt_r + 3'h1;
				if (bit_cnt_r == 3'h7) begin
					byte_r <= {shreg_r[6:0], sdin_q};
					byte_vld_r <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### verification/oprs_props.sv
// Checker for reset defaults and APB answers of oprs_top.
// Assumes binding onto every oprs_top instance.
`timescale 1ns/1ps
`default_nettype none
module oprs_props (
	// Watched ports
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic display_on_r,
	input wire logic [7:0] contrast_r,
	input wire logic [7:0] column_r,
	input wire logic [5:0] start_line_r
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire cmd_wr = acc && pwrite && paddr == 12'h000;
	a_disp_reset: assert property ($rose(presetn) |-> !display_on_r) else $error("display on after reset");
	a_contrast_reset: assert property ($rose(presetn) |-> contrast_r == 8'h7F) else $error("contrast default");
	a_column_reset: assert property ($rose(presetn) |-> column_r == 8'h00) else $error("column default");
	a_start_reset: assert property ($rose(presetn) |-> start_line_r == 6'h00) else $error("start default");
	a_bus_idle: assert property ($rose(presetn) |-> prdata == 32'h0 && !pready && !pslverr) else $error("bus not idle");
	a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready) else $error("ready not one cycle");
	a_err_map: assert property (acc |-> pslverr == (paddr > 12'h014 || paddr[1:0] != 2'b00)) else $error("slave error");
	a_disp_on_cmd: assert property (cmd_wr && pwdata[7:0] == 8'hAF |=> display_on_r) else $error("display on cmd");
	a_disp_off_cmd: assert property (cmd_wr && pwdata[7:0] == 8'hAE |=> !display_on_r) else $error("display off cmd");
	cover property ($rose(presetn));
	cover property (acc && pslverr);
	cover property ($rose(display_on_r));
endmodule
bind oprs_top oprs_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .display_on_r, .contrast_r, .column_r, .start_line_r);
`default_nettype wire

// ### verification/oprs_host_model.sv
// Host serial sender for the display driver.
// Assumes pclk at 40 MHz; each serial phase lasts 4 pclk.
`timescale 1ns/1ps
`default_nettype none
module oprs_host_model (
	// Clock
	input wire logic pclk,
	// Serial pins
	output logic chip_select_n,
	output logic serial_clk,
	output logic serial_din,
	output logic cmd_data_select
);
	initial begin
		chip_select_n = 1'b1;
		serial_clk = 1'b0;
		serial_din = 1'b0;
		cmd_data_select = 1'b0;
	end
	task automatic send(input logic cds, input logic [7:0] b, input int nbits);
		for (int i = 7; i > 7 - nbits; i--) begin
			@(posedge pclk);
			chip_select_n <= 1'b0;
			cmd_data_select <= cds;
			serial_din <= b[i];
			serial_clk <= 1'b0;
			repeat (4) @(posedge pclk);
			serial_clk <= 1'b1;
			repeat (3) @(posedge pclk);
		end
		@(posedge pclk);
		serial_clk <= 1'b0;
		// Partial byte keeps select low
		if (nbits == 8) begin
			repeat (4) @(posedge pclk);
			chip_select_n <= 1'b1;
			serial_din <= ~serial_din;
		end
	endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for oprs_top: reset defaults, power order, APB map.
// Assumes oprs_host_model drives the serial pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, chip_select_n, serial_clk, serial_din, cmd_data_select, display_on_r, er;
	logic [7:0] contrast_r, column_r;
	logic [5:0] start_line_r;
	int n_fail = 0, num_checks = 0;
	always #12.5 pclk = ~pclk;
	oprs_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.chip_select_n, .serial_clk, .serial_din, .cmd_data_select, .display_on_r, .contrast_r,
		.column_r, .start_line_r);
	oprs_host_model u_host (.pclk, .chip_select_n, .serial_clk, .serial_din, .cmd_data_select);
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k == 50) begin
			n_fail++;
			wrap_up();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic t_defaults;
		apb(1'b0, 12'h008, 32'h0);
		chk("mode", rd[2:0], 3'b000);
		chk("mapping", rd[4:3], 2'b00);
		apb(1'b0, 12'h00C, 32'h0);
		chk("contrast", rd, 32'h7F);
		apb(1'b0, 12'h010, 32'h0);
		chk("position", rd, 32'h000FC000);
		chk("column", column_r, 8'h00);
		chk("start", start_line_r, 6'h00);
	endtask
	task automatic t_unmapped;
		apb(1'b1, 12'h018, 32'hFF);
		chk("err wr", er, 1'b1);
		apb(1'b0, 12'h018, 32'h0);
		chk("err rd", rd, 32'h0);
	endtask
	task automatic t_partial;
		// Non-default state for the reset to undo
		apb(1'b1, 12'h000, 32'hAF);
		apb(1'b1, 12'h000, 32'hA1);
		u_host.send(1'b0, 8'hA7, 5);
		repeat (12) @(posedge pclk);
		apb(1'b0, 12'h010, 32'h0);
		chk("bits", rd, 32'h005FC002);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_defaults();
	endtask
	task automatic t_power_up;
		apb(1'b1, 12'h000, 32'hAE);
		u_host.send(1'b0, 8'hA1, 8);
		u_host.send(1'b0, 8'hC8, 8);
		u_host.send(1'b0, 8'h81, 8);
		u_host.send(1'b0, 8'h32, 8);
		u_host.send(1'b0, 8'h45, 8);
		u_host.send(1'b1, 8'h00, 8);
		repeat (12) @(posedge pclk);
		apb(1'b1, 12'h014, 32'h1);
		// Settle wait scaled down from 100 ms
		repeat (40) @(posedge pclk);
		apb(1'b1, 12'h000, 32'hAF);
		apb(1'b0, 12'h008, 32'h0);
		chk("state on", rd, 32'h79);
		chk("contrast set", contrast_r, 8'h32);
		chk("start set", start_line_r, 6'h05);
		chk("column inc", column_r, 8'h01);
	endtask
	task automatic t_power_down;
		apb(1'b1, 12'h000, 32'hAE);
		apb(1'b1, 12'h014, 32'h0);
		apb(1'b0, 12'h008, 32'h0);
		chk("state off", rd, 32'h38);
	endtask
	task automatic t_modes;
		apb(1'b1, 12'h000, 32'hA5);
		chk("err ok", er, 1'b0);
		apb(1'b1, 12'h000, 32'hA7);
		apb(1'b1, 12'h000, 32'hA0);
		apb(1'b1, 12'h000, 32'hC0);
		apb(1'b0, 12'h008, 32'h0);
		chk("state modes", rd, 32'h26);
		apb(1'b1, 12'h000, 32'hA4);
		apb(1'b1, 12'h000, 32'hA6);
		apb(1'b1, 12'h000, 32'h81);
		apb(1'b1, 12'h000, 32'h10);
		apb(1'b1, 12'h004, 32'h0);
		apb(1'b1, 12'h000, 32'h40);
		apb(1'b0, 12'h010, 32'h0);
		chk("pos apb", rd, 32'h000FC002);
		apb(1'b0, 12'h008, 32'h0);
		chk("state normal", rd, 32'h20);
		chk("contrast apb", contrast_r, 8'h10);
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_defaults();
		t_unmapped();
		t_power_up();
		t_power_down();
		t_modes();
		t_partial();
		wrap_up();
	end
endmodule
`default_nettype wire
